/* rtl/fb_attr_pkg.sv */
package fb_attr_pkg;
  localparam int          INT_W       = 11;
  localparam int          CODE_W      = 12;
  localparam logic [10:0] INT_MAX     = 11'h3e8;
  localparam logic [11:0] CODE_V10    = 12'hfff;
  localparam logic [11:0] CODE_MA4    = 12'h333;
  localparam logic [15:0] GAIN_MAX    = 16'h03e8;
  localparam logic [15:0] OFFSET_MAX  = 16'h2710;
  localparam logic [15:0] GAIN_RST    = 16'h0064;
  localparam logic [15:0] OFFSET_RST  = 16'h0000;
  localparam int          NUM_BLK     = 8;
  localparam int          NUM_PAR     = 8;
  localparam int          PAR_W       = 16;
  localparam int          CNT_W       = 16;
  localparam logic [7:0]  ALWAYS_RET  = 8'hf0;
  localparam logic [7:0]  RET_RST     = 8'h00;
  localparam logic [7:0]  PROT_RST    = 8'h00;
  localparam logic [3:0]  REG_RET     = 4'h0;
  localparam logic [3:0]  REG_PROT    = 4'h1;
  localparam logic [3:0]  REG_INV     = 4'h2;
  localparam logic [3:0]  REG_GAIN    = 4'h3;
  localparam logic [3:0]  REG_OFFSET  = 4'h4;
  localparam logic [3:0]  REG_MODE    = 4'h5;
  localparam logic [3:0]  REG_RAW     = 4'h6;
  localparam logic [3:0]  REG_SCALED  = 4'h7;
  localparam logic [3:0]  REG_PADDR   = 4'h8;
  localparam logic [3:0]  REG_PDATA   = 4'h9;
  localparam logic [3:0]  REG_CNT     = 4'ha;

  typedef enum logic [2:0] {
    MODE_RUN  = 3'b001,
    MODE_PARA = 3'b010,
    MODE_PROG = 3'b100
  } op_mode_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;
endpackage

/* rtl/par_mem.sv */
`timescale 1ns/10ps
`default_nettype none
module par_mem #(
  parameter int DEPTH = 8,
  parameter int W     = 16
) (
  input  wire logic                     clk_sys,
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [W-1:0]             wdata,
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output var  logic [W-1:0]             rdata
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // par_mem
`default_nettype wire

/* rtl/analog_scale.sv */
`timescale 1ns/10ps
`default_nettype none
module analog_scale (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic [11:0]       code,
  input  wire logic              current_loop,
  input  wire logic signed [15:0] gain,
  input  wire logic signed [15:0] offset,
  output var  logic [10:0]       internal,
  output var  logic signed [15:0] scaled
);
  logic [23:0]        num;
  logic [11:0]        span;
  logic [11:0]        base;
  logic [11:0]        sat;
  logic [10:0]        iv;
  logic signed [27:0] prod;
  logic signed [27:0] quot;
  logic signed [27:0] sum;

  always_comb begin
    base = current_loop ? fb_attr_pkg::CODE_MA4 : 12'h000;
    sat  = (code > fb_attr_pkg::CODE_V10) ? fb_attr_pkg::CODE_V10 : code;
    span = fb_attr_pkg::CODE_V10 - base;
    if (sat <= base) begin
      num = 24'h000000;
    end else begin
      num = 24'(sat - base) * 24'(fb_attr_pkg::INT_MAX);
    end
    iv = 11'(num / span);
    if (iv > fb_attr_pkg::INT_MAX) begin
      iv = fb_attr_pkg::INT_MAX;
    end
    prod = $signed({17'h00000, iv}) * 28'(gain);
    quot = prod / 28'sd100;
    sum  = quot + 28'(offset);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      internal <= 11'h000;
      scaled   <= 16'sh0000;
    end else begin
      internal <= iv;
      scaled   <= 16'(sum);
    end
  end
endmodule // analog_scale
`default_nettype wire

/* rtl/fb_attr.sv */
// Summary of operation
// - retaining blocks keep state over power loss
// - retained timers resume counting remaining time
// - retention off by default
// - hours, weekly, yearly, PI always retain
// - parameters open in parameter mode by default
// - protected parameters only in programming mode
// - 0-10 V maps linearly to 0-1000
// - 0/4-20 mA maps to 0-1000
// - over-range input saturates at 1000
// - result is internal times gain/100 plus offset
// - each block input individually invertible
`timescale 1ns/10ps
`default_nettype none
module fb_attr #(
  parameter int NBLK = fb_attr_pkg::NUM_BLK
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              power_ok,
  input  wire logic [NBLK-1:0]   tick,
  input  wire logic [NBLK-1:0]   blk_in,
  input  wire logic [11:0]       ain_code,
  input  wire fb_attr_pkg::reg_req_t req,
  output logic [15:0]            rdata,
  output logic [NBLK-1:0]        blk_in_eff,
  output logic [NBLK-1:0]        blk_running,
  output logic signed [15:0]     ain_scaled
);
  typedef struct packed {
    logic [7:0]              ret;
    logic [7:0]              prot;
    logic [7:0]              inv;
    logic [15:0]             gain;
    logic [15:0]             offset;
    fb_attr_pkg::op_mode_t   mode;
    logic                    cloop;
    logic [2:0]              paddr;
    logic [7:0]              cnt_sel;
    logic [NBLK-1:0][15:0]   cnt;
    logic [NBLK-1:0]         run;
    logic [NBLK-1:0]         eff;
    logic [15:0]             rdata;
    logic                    pend_par;
  } state_t;

  state_t q;
  state_t d;
  logic        pwe;
  logic [15:0] prd;
  logic [10:0] ain_int;
  logic signed [15:0] ain_sc;

  function automatic logic par_visible(input fb_attr_pkg::op_mode_t m,
                                       input logic p);
    par_visible = (m == fb_attr_pkg::MODE_PROG) ||
                  ((m == fb_attr_pkg::MODE_PARA) && !p);
  endfunction

  function automatic logic [15:0] clip(input logic [15:0] v,
                                       input logic [15:0] lim);
    logic signed [15:0] s;
    s = $signed(v);
    if (s > $signed(lim)) begin
      clip = lim;
    end else if (s < -$signed(lim)) begin
      clip = 16'(-$signed(lim));
    end else begin
      clip = v;
    end
  endfunction

  par_mem #(
    .DEPTH (fb_attr_pkg::NUM_PAR),
    .W     (fb_attr_pkg::PAR_W)
  ) u_par (
    .clk_sys (clk_sys),
    .we      (pwe),
    .waddr   (q.paddr),
    .wdata   (req.wdata),
    .raddr   (q.paddr),
    .rdata   (prd)
  );

  analog_scale u_scale (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .code         (ain_code),
    .current_loop (q.cloop),
    .gain         ($signed(q.gain)),
    .offset       ($signed(q.offset)),
    .internal     (ain_int),
    .scaled       (ain_sc)
  );

  assign pwe = req.wr && (req.addr == fb_attr_pkg::REG_PDATA) &&
               par_visible(q.mode, q.prot[q.paddr]);

  always_comb begin
    d = q;
    d.pend_par = 1'b0;
    d.eff = blk_in ^ q.inv;
    // power loss: drop non-retaining state, keep retained counters
    if (!power_ok) begin
      for (int i = 0; i < NBLK; i++) begin
        if (!(q.ret[i] || fb_attr_pkg::ALWAYS_RET[i])) begin
          d.cnt[i] = 16'h0000;
          d.run[i] = 1'b0;
        end
      end
    end else begin
      for (int i = 0; i < NBLK; i++) begin
        if (tick[i] && q.run[i] && q.cnt[i] != 16'h0000) begin
          d.cnt[i] = q.cnt[i] - 16'h0001;
        end
        if (q.cnt[i] == 16'h0000) begin
          d.run[i] = 1'b0;
        end
      end
    end
    if (req.wr) begin
      case (req.addr)
        fb_attr_pkg::REG_RET:    d.ret = req.wdata[7:0];
        fb_attr_pkg::REG_PROT: begin
          if (q.mode == fb_attr_pkg::MODE_PROG) begin
            d.prot = req.wdata[7:0];
          end
        end
        fb_attr_pkg::REG_INV:    d.inv = req.wdata[7:0];
        fb_attr_pkg::REG_GAIN:
          d.gain = clip(req.wdata, fb_attr_pkg::GAIN_MAX);
        fb_attr_pkg::REG_OFFSET:
          d.offset = clip(req.wdata, fb_attr_pkg::OFFSET_MAX);
        fb_attr_pkg::REG_MODE: begin
          case (req.wdata[1:0])
            2'h1:    d.mode = fb_attr_pkg::MODE_PARA;
            2'h2:    d.mode = fb_attr_pkg::MODE_PROG;
            default: d.mode = fb_attr_pkg::MODE_RUN;
          endcase
          d.cloop = req.wdata[4];
        end
        fb_attr_pkg::REG_PADDR: begin
          d.paddr   = req.wdata[2:0];
          d.cnt_sel = req.wdata[15:8];
        end
        fb_attr_pkg::REG_CNT: begin
          d.cnt[q.cnt_sel[2:0]] = req.wdata;
          d.run[q.cnt_sel[2:0]] = req.wdata != 16'h0000;
        end
        default: ;
      endcase
    end
    d.rdata = 16'h0000;
    if (req.rd) begin
      case (req.addr)
        fb_attr_pkg::REG_RET:    d.rdata = {8'h00, q.ret | fb_attr_pkg::ALWAYS_RET};
        fb_attr_pkg::REG_PROT:   d.rdata = {8'h00, q.prot};
        fb_attr_pkg::REG_INV:    d.rdata = {8'h00, q.inv};
        fb_attr_pkg::REG_GAIN:   d.rdata = q.gain;
        fb_attr_pkg::REG_OFFSET: d.rdata = q.offset;
        fb_attr_pkg::REG_MODE:   d.rdata = {11'h000, q.cloop, 1'b0, q.mode};
        fb_attr_pkg::REG_RAW:    d.rdata = {5'h00, ain_int};
        fb_attr_pkg::REG_SCALED: d.rdata = ain_sc;
        fb_attr_pkg::REG_PADDR:  d.rdata = {q.cnt_sel, 5'h00, q.paddr};
        fb_attr_pkg::REG_CNT:    d.rdata = q.cnt[q.cnt_sel[2:0]];
        fb_attr_pkg::REG_PDATA:  d.pend_par = 1'b1;
        default:                 d.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q        <= '0;
      q.ret    <= fb_attr_pkg::RET_RST;
      q.prot   <= fb_attr_pkg::PROT_RST;
      q.gain   <= fb_attr_pkg::GAIN_RST;
      q.offset <= fb_attr_pkg::OFFSET_RST;
      q.mode   <= fb_attr_pkg::MODE_RUN;
    end else begin
      q <= d;
    end
  end

  // parameter read data comes from memory register, gated by protection
  always_comb begin
    if (q.pend_par) begin
      rdata = par_visible(q.mode, q.prot[q.paddr]) ? prd : 16'h0000;
    end else begin
      rdata = q.rdata;
    end
  end

  assign blk_in_eff  = q.eff;
  assign blk_running = q.run;
  assign ain_scaled  = ain_sc;
endmodule // fb_attr
`default_nettype wire

/* testbench/fb_attr_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module fb_attr_asserts #(
  parameter int NBLK = 8
) (
  input wire logic                  clk_sys,
  input wire logic                  rst,
  input wire logic                  power_ok,
  input wire logic [NBLK-1:0]       tick,
  input wire logic [NBLK-1:0]       blk_in,
  input wire logic [11:0]           ain_code,
  input wire fb_attr_pkg::reg_req_t req,
  input wire logic [15:0]           rdata,
  input wire logic [NBLK-1:0]       blk_in_eff,
  input wire logic [NBLK-1:0]       blk_running,
  input wire logic signed [15:0]    ain_scaled
);
  logic [7:0] ret_q, prot_q, inv_q;
  logic [1:0] mode_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // shadow of the retention, protection, inversion and mode settings
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {ret_q, prot_q, inv_q, mode_q} <= '0;
    end else if (req.wr) begin
      if (req.addr == 4'h0) ret_q <= req.wdata[7:0];
      if (req.addr == 4'h1 && mode_q == 2'h2) prot_q <= req.wdata[7:0];
      if (req.addr == 4'h2) inv_q <= req.wdata[7:0];
      if (req.addr == 4'h5) mode_q <= req.wdata[1:0];
    end
  end
  AST_RD_IDLE: assert property (!req.rd |=> rdata == 16'h0000)
    else $error("read data not idle");
  AST_INV: assert property (1 |=> blk_in_eff == ($past(blk_in) ^ $past(inv_q)))
    else $error("input inversion wrong");
  AST_RAW_FULL: assert property (req.rd && req.addr == 4'h6
    && ain_code == 12'hfff && $past(ain_code) == 12'hfff
    && $past(ain_code, 2) == 12'hfff |=> rdata == 16'h03e8)
    else $error("full scale not 1000");
  AST_RET_RD: assert property (req.rd && req.addr == 4'h0
    |=> rdata[7:0] == ($past(ret_q) | 8'hf0))
    else $error("retention read wrong");
  AST_PROT_RD: assert property (req.rd && req.addr == 4'h1
    |=> rdata[7:0] == $past(prot_q))
    else $error("protection read wrong");
  AST_PWR_CLR: assert property (!power_ok
    |=> (blk_running & ~($past(ret_q) | 8'hf0)) == 8'h00)
    else $error("volatile block kept running");
  AST_PWR_HOLD: assert property (!power_ok |=>
    ((blk_running ^ $past(blk_running)) & ($past(ret_q) | 8'hf0)) == 8'h00)
    else $error("retained block changed");
  AST_SCALED: assert property (req.rd && req.addr == 4'h7
    |=> rdata == $past(ain_scaled))
    else $error("scaled read mismatch");
endmodule // fb_attr_asserts
bind fb_attr fb_attr_asserts #(.NBLK(NBLK)) chk (.clk_sys(clk_sys),
  .rst(rst), .power_ok(power_ok), .tick(tick), .blk_in(blk_in),
  .ain_code(ain_code), .req(req), .rdata(rdata), .blk_in_eff(blk_in_eff),
  .blk_running(blk_running), .ain_scaled(ain_scaled));
`default_nettype wire

/* testbench/sensor_model.sv */
`timescale 1ns/10ps
`default_nettype none
module sensor_model (
  input  wire logic [15:0] level,
  output logic      [11:0] ain_code
);
  // level in millivolts; converter clips above full scale
  assign ain_code = (level >= 16'd10000) ? 12'hfff
                  : 12'((32'(level) * 32'd4095) / 32'd10000);
endmodule // sensor_model
`default_nettype wire

/* testbench/tb_function_block_attributes_scaling.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_function_block_attributes_scaling;
  logic                  clk_sys = 1'b0;
  logic                  rst = 1'b1;
  logic                  power_ok = 1'b1;
  logic [7:0]            tick = 8'h00;
  logic [7:0]            blk_in = 8'h00;
  logic [15:0]           level = 16'h0000;
  logic [11:0]           ain_code;
  fb_attr_pkg::reg_req_t req = '0;
  logic [15:0]           rdata, g, o;
  logic [7:0]            eff, run;
  logic signed [15:0]    scaled;
  logic [15:0]           exp_q[$];
  logic                  rd_seen = 1'b0;
  int                    blks[3] = '{0, 1, 4};
  int                    error_cnt = 0;
  int                    num_checks = 0;
  always #50 clk_sys = ~clk_sys;
  sensor_model sens (.level(level), .ain_code(ain_code));
  fb_attr dut (.clk_sys(clk_sys), .rst(rst), .power_ok(power_ok),
    .tick(tick), .blk_in(blk_in), .ain_code(ain_code), .req(req),
    .rdata(rdata), .blk_in_eff(eff), .blk_running(run),
    .ain_scaled(scaled));
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t read %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t flags %h want %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // write d, or read and expect d
  task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
    req <= '{addr: a, wdata: w ? d : 16'h0000, wr: w, rd: !w};
    if (!w) exp_q.push_back(d);
    @(posedge clk_sys);
    req <= '0;
    @(posedge clk_sys);
  endtask
  task automatic ain(input logic [15:0] mv, input logic [15:0] raw);
    level <= mv;
    repeat (4) @(posedge clk_sys);
    acc(0, 4'h6, raw);
  endtask
  task automatic pulse;
    tick <= 8'h11;
    @(posedge clk_sys);
    tick <= 8'h00;
    @(posedge clk_sys);
  endtask
  always @(posedge clk_sys) begin
    if (rd_seen) chk16(rdata, exp_q.pop_front());
    rd_seen <= req.rd;
  end
  initial begin
    void'($urandom(50090));
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    acc(0, 4'h0, 16'h00f0);
    acc(1, 4'h1, 16'h0001);
    acc(0, 4'h1, 16'h0000);
    acc(1, 4'h5, 16'h0001);
    acc(1, 4'h9, 16'h1234);
    acc(0, 4'h9, 16'h1234);
    acc(1, 4'h5, 16'h0002);
    acc(1, 4'h1, 16'h0001);
    acc(0, 4'h1, 16'h0001);
    acc(1, 4'h9, 16'h5678);
    acc(1, 4'h5, 16'h0001);
    acc(1, 4'h9, 16'h9abc);
    acc(0, 4'h9, 16'h0000);
    acc(1, 4'h5, 16'h0012);
    acc(0, 4'h9, 16'h5678);
    ain(16'd2000, 16'h0000);
    ain(16'd10000, 16'h03e8);
    acc(1, 4'h5, 16'h0002);
    ain(16'd12000, 16'h03e8);
    ain(16'd0, 16'h0000);
    acc(1, 4'h3, 16'd2000);
    acc(0, 4'h3, 16'h03e8);
    for (int i = 0; i < 6; i++) begin
      g = 16'($urandom_range(2000)) - 16'd1000;
      o = 16'($urandom_range(20000)) - 16'd10000;
      acc(1, 4'h3, g);
      acc(1, 4'h4, o);
      ain(i[0] ? 16'd10000 : 16'd0, i[0] ? 16'h03e8 : 16'h0000);
      acc(0, 4'h7, i[0] ? 16'($signed(g) * 10) + o : o);
    end
    // small product: internal 2 times 0.01 truncates to 0
    acc(1, 4'h4, 16'h0000);
    acc(1, 4'h3, 16'h0001);
    ain(16'd22, 16'h0002);
    acc(0, 4'h7, 16'h0000);
    acc(1, 4'h3, 16'h03e8);
    acc(0, 4'h7, 16'h0014);
    chk16(scaled, 16'h0014);
    for (int i = 0; i < 4; i++) begin
      g = 16'($urandom);
      acc(1, 4'h2, g);
      blk_in <= 8'($urandom);
      repeat (2) @(posedge clk_sys);
      chk8(eff, blk_in ^ g[7:0]);
    end
    acc(1, 4'h0, 16'h0001);
    foreach (blks[i]) begin
      acc(1, 4'h8, 16'(blks[i] << 8));
      acc(1, 4'ha, 16'h0003);
    end
    chk8(run, 8'h13);
    power_ok <= 1'b0;
    repeat (3) @(posedge clk_sys);
    power_ok <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk8(run, 8'h11);
    acc(0, 4'ha, 16'h0003);
    pulse;
    pulse;
    chk8(run, 8'h11);
    pulse;
    @(posedge clk_sys);
    chk8(run, 8'h00);
    tally_and_finish();
  end
  initial begin
    repeat (3000) @(posedge clk_sys);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule // tb_function_block_attributes_scaling
`default_nettype wire
